//--- rtl/preset_speed_selector.sv
// Preset speed selector: select inputs, preset store, settling mask, reference and ramp.
//
// Summary of operation
// - Up to sixteen preset frequencies are stored and the select inputs choose which one is the reference.
// - A change of preset is followed by ramping at the accel or decel rate, never by a step.
// - Preset zero has a copy for each motor, presets one to fifteen have one copy that both motors use.
// - Binary selection, the reset default, offers sixteen presets from four select inputs.
// - Bit selection offers eight presets from seven select inputs.
// - After reset preset zero of both motors is 6.00 Hz and presets one to fifteen are 0.00 Hz.
// - Select combination changes are masked for 0 to 200 units of 10 ms, default 0 meaning none.
// - In binary selection the first select input is bit 0 and the fourth is bit 3 of the index.
// - In bit selection all inputs off gives preset zero, else the lowest active input n gives preset n.
// - When preset zero is chosen the frequency source setting decides what the reference is.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module preset_speed_selector
  import preset_speed_pkg::*;
#(
  parameter int MASK_TICK_CYCLES = MASK_UNIT_CYCLES,
  parameter int RAMP_CYCLES      = RAMP_TICK_CYCLES
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire select_pins_t      i_select_pins,
  input  wire logic              i_motor2_sel,
  input  wire logic [FREQ_W-1:0] i_ext_freq,
  input  wire reg_req_t          i_reg_req,
  output logic      [DATA_W-1:0] o_rdata,
  output logic      [FREQ_W-1:0] o_out_freq,
  output logic      [FREQ_W-1:0] o_freq_ref,
  output logic      [IDX_W-1:0]  o_preset_index
);

  localparam int SEL_W = $bits(select_pins_t);

  // Two-stage synchronisers for the terminals.
  select_pins_t      pins_s1_q;
  select_pins_t      pins_s2_q;
  logic              motor2_s1_q;
  logic              motor2_s2_q;

  // Configuration and preset storage.
  logic [FREQ_W-1:0] preset_q   [NUM_PRESETS];
  logic [FREQ_W-1:0] preset_d   [NUM_PRESETS];
  logic [FREQ_W-1:0] zero_m2_q, zero_m2_d;
  selection_method_t sel_method_q, sel_method_d;
  logic [MASK_W-1:0] mask_q, mask_d;
  logic [1:0]        fsrc_q, fsrc_d;
  logic [FREQ_W-1:0] fmax_q, fmax_d;
  logic [FREQ_W-1:0] fstart_q, fstart_d;
  logic [FREQ_W-1:0] accel_q, accel_d;
  logic [FREQ_W-1:0] decel_q, decel_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  // Selection, reference and tick state.
  logic [IDX_W-1:0]  index_q, index_d;
  logic [FREQ_W-1:0] ref_q, ref_d;
  logic [FREQ_W-1:0] out_q;
  logic [16:0]       mask_div_q, mask_div_d;
  logic [16:0]       ramp_div_q, ramp_div_d;
  logic              mask_tick_q, mask_tick_d;
  logic              ramp_tick_q, ramp_tick_d;

  // Combinational helpers.
  select_pins_t      stable;
  logic [SEL_W-1:0]  stable_bits;
  logic [1:0]        ramp_state;
  logic [FREQ_W-1:0] wval;
  logic              wval_ok;
  logic [FREQ_W-1:0] chosen;

  // Terminals come from outside the clock domain, so each passes two flops first.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pins_s1_q   <= '0;
      pins_s2_q   <= '0;
      motor2_s1_q <= 1'b0;
      motor2_s2_q <= 1'b0;
    end else begin
      pins_s1_q   <= i_select_pins;
      pins_s2_q   <= pins_s1_q;
      motor2_s1_q <= i_motor2_sel;
      motor2_s2_q <= motor2_s1_q;
    end
  end

  // Dividers make the 10 ms mask unit and the ramp step interval as one-cycle enables.
  always_comb begin
    mask_div_d  = mask_div_q + 17'h00001;
    mask_tick_d = 1'b0;
    if (mask_div_q >= 17'(MASK_TICK_CYCLES - 1)) begin
      mask_div_d  = '0;
      mask_tick_d = 1'b1;
    end
    ramp_div_d  = ramp_div_q + 17'h00001;
    ramp_tick_d = 1'b0;
    if (ramp_div_q >= 17'(RAMP_CYCLES - 1)) begin
      ramp_div_d  = '0;
      ramp_tick_d = 1'b1;
    end
  end

  // Divider registers.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_div_q  <= '0;
      ramp_div_q  <= '0;
      mask_tick_q <= 1'b0;
      ramp_tick_q <= 1'b0;
    end else begin
      mask_div_q  <= mask_div_d;
      ramp_div_q  <= ramp_div_d;
      mask_tick_q <= mask_tick_d;
      ramp_tick_q <= ramp_tick_d;
    end
  end

  // The whole combination is masked at once, so a slow multi-switch change settles as one.
  settle_filter #(
    .WIDTH (SEL_W)
  ) u_settle (
    .i_mclk   (i_mclk),
    .i_rstn   (i_rstn),
    .i_tick   (mask_tick_q),
    .i_mask   (mask_q),
    .i_raw    (pins_s2_q),
    .o_stable (stable_bits)
  );
  assign stable = select_pins_t'(stable_bits);

  // Index resolution; the user is expected to wire low-order binary inputs first.
  always_comb begin
    index_d = 4'h0;
    if (sel_method_q == SEL_BIT) begin
      if (stable.bit_select_in1) begin
        index_d = 4'h1;
      end else if (stable.bit_select_in2) begin
        index_d = 4'h2;
      end else if (stable.bit_select_in3) begin
        index_d = 4'h3;
      end else if (stable.bit_select_in4) begin
        index_d = 4'h4;
      end else if (stable.bit_select_in5) begin
        index_d = 4'h5;
      end else if (stable.bit_select_in6) begin
        index_d = 4'h6;
      end else if (stable.bit_select_in7) begin
        index_d = 4'h7;
      end
    end else begin
      index_d = {stable.bin_select_bit3, stable.bin_select_bit2,
                 stable.bin_select_bit1, stable.bin_select_bit0};
    end
  end

  // Reference from the chosen preset, clamped to the maximum frequency.
  always_comb begin
    chosen = preset_q[index_q];
    if (index_q == 4'h0) begin
      if (fsrc_q != FSRC_PRESET) begin
        chosen = i_ext_freq;
      end else if (motor2_s2_q) begin
        chosen = zero_m2_q;
      end
    end
    ref_d = (chosen > fmax_q) ? fmax_q : chosen;
  end

  // Selection registers.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      index_q <= 4'h0;
      ref_q   <= '0;
    end else begin
      index_q <= index_d;
      ref_q   <= ref_d;
    end
  end

  // Ramp toward the reference.
  freq_ramp u_ramp (
    .i_mclk       (i_mclk),
    .i_rstn       (i_rstn),
    .i_tick       (ramp_tick_q),
    .i_target     (ref_q),
    .i_accel_step (accel_q),
    .i_decel_step (decel_q),
    .o_freq       (out_q),
    .o_state      (ramp_state)
  );

  // Register writes; an out-of-range value is dropped and the old setting stays, except that source and step writes take their low bits unchecked.
  always_comb begin
    preset_d     = preset_q;
    zero_m2_d    = zero_m2_q;
    sel_method_d = sel_method_q;
    mask_d       = mask_q;
    fsrc_d       = fsrc_q;
    fmax_d       = fmax_q;
    fstart_d     = fstart_q;
    accel_d      = accel_q;
    decel_d      = decel_q;
    wval         = i_reg_req.wdata[FREQ_W-1:0];
    wval_ok      = (i_reg_req.wdata[DATA_W-1:FREQ_W] == '0) &&
                   ((wval == '0) || ((wval >= fstart_q) && (wval <= FREQ_LIMIT)));
    if (i_reg_req.wr) begin
      if (i_reg_req.addr >= OFS_PRESET_BASE && i_reg_req.addr < OFS_PRESET_BASE + 8'h40 &&
          i_reg_req.addr[1:0] == 2'h0) begin
        if (wval_ok) begin
          preset_d[i_reg_req.addr[5:2]] = wval;
        end
      end else begin
        case (i_reg_req.addr)
          OFS_SELECTION_METHOD: begin
            if (i_reg_req.wdata[DATA_W-1:2] == '0 && i_reg_req.wdata[1] == 1'b0) begin
              sel_method_d = selection_method_t'(i_reg_req.wdata[1:0]);
            end
          end
          OFS_SETTLE_MASK_TIME: begin
            if (i_reg_req.wdata[DATA_W-1:MASK_W] == '0 && i_reg_req.wdata[MASK_W-1:0] <= MASK_LIMIT) begin
              mask_d = i_reg_req.wdata[MASK_W-1:0];
            end
          end
          OFS_FREQUENCY_SOURCE: begin
            fsrc_d = i_reg_req.wdata[1:0];
          end
          OFS_MAXIMUM_FREQ: begin
            if (i_reg_req.wdata[DATA_W-1:FREQ_W] == '0 && wval <= FREQ_LIMIT) begin
              fmax_d = wval;
            end
          end
          OFS_START_FREQ: begin
            if (i_reg_req.wdata[DATA_W-1:FREQ_W] == '0 && wval <= FREQ_LIMIT) begin
              fstart_d = wval;
            end
          end
          OFS_ACCEL_STEP: begin
            accel_d = wval;
          end
          OFS_DECEL_STEP: begin
            decel_d = wval;
          end
          OFS_PRESET_ZERO_M2: begin
            if (wval_ok) begin
              zero_m2_d = wval;
            end
          end
          default: begin
            zero_m2_d = zero_m2_q;
          end
        endcase
      end
    end
  end

  // Register reads answer in the following cycle; unmapped addresses read zero.
  always_comb begin
    rdata_d = '0;
    if (i_reg_req.rd) begin
      if (i_reg_req.addr >= OFS_PRESET_BASE && i_reg_req.addr < OFS_PRESET_BASE + 8'h40 &&
          i_reg_req.addr[1:0] == 2'h0) begin
        rdata_d = {16'h0000, preset_q[i_reg_req.addr[5:2]]};
      end else begin
        case (i_reg_req.addr)
          OFS_SELECTION_METHOD: rdata_d = {30'h00000000, sel_method_q};
          OFS_SETTLE_MASK_TIME: rdata_d = {24'h000000, mask_q};
          OFS_FREQUENCY_SOURCE: rdata_d = {30'h00000000, fsrc_q};
          OFS_MAXIMUM_FREQ:     rdata_d = {16'h0000, fmax_q};
          OFS_START_FREQ:       rdata_d = {16'h0000, fstart_q};
          OFS_ACCEL_STEP:       rdata_d = {16'h0000, accel_q};
          OFS_DECEL_STEP:       rdata_d = {16'h0000, decel_q};
          OFS_STATUS:           rdata_d = {ref_q, 5'h00, motor2_s2_q, ramp_state, 4'h0, index_q};
          OFS_OUTPUT_FREQ:      rdata_d = {16'h0000, out_q};
          OFS_PRESET_ZERO_M2:   rdata_d = {16'h0000, zero_m2_q};
          default:              rdata_d = '0;
        endcase
      end
    end
  end

  // Preset store with its reset image, one entry per generate pass.
  for (genvar g = 0; g < NUM_PRESETS; g++) begin : g_preset
    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
        preset_q[g] <= (g == 0) ? RST_PRESET_ZERO : RST_PRESET_OTHER;
      end else begin
        preset_q[g] <= preset_d[g];
      end
    end
  end

  // Configuration registers and read data.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      zero_m2_q    <= RST_PRESET_ZERO;
      sel_method_q <= RST_SELECTION;
      mask_q       <= RST_SETTLE_MASK;
      fsrc_q       <= RST_FREQUENCY_SOURCE;
      fmax_q       <= RST_MAXIMUM_FREQ;
      fstart_q     <= RST_START_FREQ;
      accel_q      <= RST_ACCEL_STEP;
      decel_q      <= RST_DECEL_STEP;
      rdata_q      <= '0;
    end else begin
      zero_m2_q    <= zero_m2_d;
      sel_method_q <= sel_method_d;
      mask_q       <= mask_d;
      fsrc_q       <= fsrc_d;
      fmax_q       <= fmax_d;
      fstart_q     <= fstart_d;
      accel_q      <= accel_d;
      decel_q      <= decel_d;
      rdata_q      <= rdata_d;
    end
  end

  // Outputs come straight from flops.
  assign o_rdata        = rdata_q;
  assign o_out_freq     = out_q;
  assign o_freq_ref     = ref_q;
  assign o_preset_index = index_q;

endmodule
`default_nettype wire

//--- common/preset_speed_pkg.sv
// Package with register map, reset values, timing and carrier types of the preset speed selector.
`default_nettype none
package preset_speed_pkg;

  // Clock and timing figures.
  localparam int CLK_HZ            = 10_000_000;
  localparam int MASK_UNIT_MS      = 10;
  localparam int MASK_UNIT_CYCLES  = CLK_HZ / 1000 * MASK_UNIT_MS;
  localparam int RAMP_TICK_US      = 1000;
  localparam int RAMP_TICK_CYCLES  = CLK_HZ / 1_000_000 * RAMP_TICK_US;

  // Widths and counts.
  localparam int FREQ_W            = 16;
  localparam int NUM_PRESETS       = 16;
  localparam int IDX_W             = 4;
  localparam int ADDR_W            = 8;
  localparam int DATA_W            = 32;
  localparam int MASK_W            = 8;

  // Frequency limit in 0.01 Hz steps, and mask limit in 10 ms units.
  localparam logic [15:0] FREQ_LIMIT        = 16'h9c40;
  localparam logic [7:0]  MASK_LIMIT        = 8'hc8;

  // Register byte offsets.
  localparam logic [7:0] OFS_SELECTION_METHOD = 8'h00;
  localparam logic [7:0] OFS_SETTLE_MASK_TIME = 8'h04;
  localparam logic [7:0] OFS_FREQUENCY_SOURCE = 8'h08;
  localparam logic [7:0] OFS_MAXIMUM_FREQ     = 8'h0c;
  localparam logic [7:0] OFS_START_FREQ       = 8'h10;
  localparam logic [7:0] OFS_ACCEL_STEP       = 8'h14;
  localparam logic [7:0] OFS_DECEL_STEP       = 8'h18;
  localparam logic [7:0] OFS_STATUS           = 8'h1c;
  localparam logic [7:0] OFS_OUTPUT_FREQ      = 8'h20;
  localparam logic [7:0] OFS_PRESET_ZERO_M2   = 8'h24;
  localparam logic [7:0] OFS_PRESET_BASE      = 8'h40;

  // Reset values.
  localparam logic [15:0] RST_PRESET_ZERO     = 16'h0258;
  localparam logic [15:0] RST_PRESET_OTHER    = 16'h0000;
  localparam logic [7:0]  RST_SETTLE_MASK     = 8'h00;
  localparam logic [15:0] RST_MAXIMUM_FREQ    = 16'h1388;
  localparam logic [15:0] RST_START_FREQ      = 16'h0032;
  localparam logic [15:0] RST_ACCEL_STEP      = 16'h0001;
  localparam logic [15:0] RST_DECEL_STEP      = 16'h0001;

  // Selection method codes.
  typedef enum logic [1:0] {
    SEL_BINARY = 2'h0,
    SEL_BIT    = 2'h1
  } selection_method_t;
  localparam selection_method_t RST_SELECTION = SEL_BINARY;

  // Frequency source codes; only the preset code takes preset zero from storage.
  localparam logic [1:0] FSRC_PRESET = 2'h2;
  localparam logic [1:0] RST_FREQUENCY_SOURCE = 2'h2;

  // Select terminals as they arrive from the pins.
  typedef struct packed {
    logic bit_select_in7;
    logic bit_select_in6;
    logic bit_select_in5;
    logic bit_select_in4;
    logic bit_select_in3;
    logic bit_select_in2;
    logic bit_select_in1;
    logic bin_select_bit3;
    logic bin_select_bit2;
    logic bin_select_bit1;
    logic bin_select_bit0;
  } select_pins_t;

  // Register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage
`default_nettype wire

//--- rtl/settle_filter.sv
// Settling mask that holds back a changed select combination until it has stayed stable.
`timescale 1ns/10ps
`default_nettype none
module settle_filter
  import preset_speed_pkg::*;
#(
  parameter int WIDTH = 11
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic              i_tick,
  input  wire logic [MASK_W-1:0] i_mask,
  input  wire logic [WIDTH-1:0]  i_raw,
  output logic      [WIDTH-1:0]  o_stable
);

  logic [WIDTH-1:0]  last_q, last_d;
  logic [WIDTH-1:0]  stable_q, stable_d;
  logic [MASK_W-1:0] cnt_q, cnt_d;

  // A change restarts the count; the old combination stands until the count reaches the mask.
  // The count runs on the shared 10 ms tick, so the first unit may be short by up to one tick.
  always_comb begin
    last_d   = last_q;
    stable_d = stable_q;
    cnt_d    = cnt_q;
    if (i_raw != last_q) begin
      last_d = i_raw;
      cnt_d  = '0;
      if (i_mask == '0) begin
        stable_d = i_raw;
      end
    end else if (cnt_q >= i_mask) begin
      stable_d = last_q;
    end else if (i_tick) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // State registers.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_q   <= '0;
      stable_q <= '0;
      cnt_q    <= '0;
    end else begin
      last_q   <= last_d;
      stable_q <= stable_d;
      cnt_q    <= cnt_d;
    end
  end

  assign o_stable = stable_q;

endmodule
`default_nettype wire

//--- rtl/freq_ramp.sv
// Ramp that walks the output frequency toward the reference at the accel or decel rate.
`timescale 1ns/10ps
`default_nettype none
module freq_ramp
  import preset_speed_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic              i_tick,
  input  wire logic [FREQ_W-1:0] i_target,
  input  wire logic [FREQ_W-1:0] i_accel_step,
  input  wire logic [FREQ_W-1:0] i_decel_step,
  output logic      [FREQ_W-1:0] o_freq,
  output logic      [1:0]        o_state
);

  typedef enum logic [1:0] {
    RAMP_HOLD  = 2'h0,
    RAMP_ACCEL = 2'h1,
    RAMP_DECEL = 2'h3
  } ramp_state_t;

  ramp_state_t       state_q, state_d;
  logic [FREQ_W-1:0] freq_q, freq_d;
  logic [FREQ_W-1:0] gap;

  // One step per tick, never overshooting, so a new preset is reached without a jump.
  always_comb begin
    state_d = state_q;
    freq_d  = freq_q;
    gap     = '0;
    case (state_q)
      RAMP_HOLD: begin
        if (i_target > freq_q) begin
          state_d = RAMP_ACCEL;
        end else if (i_target < freq_q) begin
          state_d = RAMP_DECEL;
        end
      end
      RAMP_ACCEL: begin
        if (i_target <= freq_q) begin
          state_d = RAMP_HOLD;
        end else if (i_tick) begin
          gap    = i_target - freq_q;
          freq_d = (gap > i_accel_step) ? freq_q + i_accel_step : i_target;
        end
      end
      RAMP_DECEL: begin
        if (i_target >= freq_q) begin
          state_d = RAMP_HOLD;
        end else if (i_tick) begin
          gap    = freq_q - i_target;
          freq_d = (gap > i_decel_step) ? freq_q - i_decel_step : i_target;
        end
      end
      default: begin
        state_d = RAMP_HOLD;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= RAMP_HOLD;
      freq_q  <= '0;
    end else begin
      state_q <= state_d;
      freq_q  <= freq_d;
    end
  end

  assign o_freq  = freq_q;
  assign o_state = state_q;

endmodule
`default_nettype wire

//--- sim/preset_speed_checker.sv
// Checker of selection, settling, reference and ramp behaviour at the selector ports.
`timescale 1ns/10ps
`default_nettype none
module preset_speed_checker
  import preset_speed_pkg::*;
#(
  parameter int MASK_TICK_CYCLES = MASK_UNIT_CYCLES,
  parameter int RAMP_CYCLES      = RAMP_TICK_CYCLES
) (
  input wire logic              i_mclk,
  input wire logic              i_rstn,
  input wire select_pins_t      i_select_pins,
  input wire logic              i_motor2_sel,
  input wire logic [FREQ_W-1:0] i_ext_freq,
  input wire reg_req_t          i_reg_req,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [FREQ_W-1:0] o_out_freq,
  input wire logic [FREQ_W-1:0] o_freq_ref,
  input wire logic [IDX_W-1:0]  o_preset_index
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  logic [1:0]   mode_q;
  logic [1:0]   fsrc_q;
  logic [7:0]   mask_q;
  logic [7:0]   age_q;
  logic [15:0]  fmax_q;
  logic [15:0]  step_q;
  logic [31:0]  cnt_q;
  logic [31:0]  lat;
  select_pins_t prev_q;
  logic [7:0]   a;
  logic [31:0]  d;
  assign a = i_reg_req.addr;
  assign d = i_reg_req.wdata;

  // Shadows of accepted writes; refused values are skipped so a dropped write is never mirrored.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q <= 2'h0;
      fsrc_q <= 2'h2;
      mask_q <= 8'h0;
      age_q  <= 8'h0;
      fmax_q <= 16'h1388;
      step_q <= 16'h1;
      cnt_q  <= 32'h0;
      prev_q <= '0;
    end else begin
      prev_q <= i_select_pins;
      cnt_q  <= (i_select_pins != prev_q) ? 32'h0 : cnt_q + 32'h1;
      age_q  <= (age_q == 8'hff) ? age_q : age_q + 8'h1;
      if (i_reg_req.wr) begin
        if (a == OFS_SELECTION_METHOD && d <= 32'h1) mode_q <= d[1:0];
        if (a == OFS_SETTLE_MASK_TIME && d <= 32'hc8) mask_q <= d[7:0];
        if (a == OFS_SELECTION_METHOD || a == OFS_SETTLE_MASK_TIME) age_q <= 8'h0;
        if (a == OFS_FREQUENCY_SOURCE) fsrc_q <= d[1:0];
        if (a == OFS_MAXIMUM_FREQ && d <= 32'h9c40) fmax_q <= d[15:0];
        if ((a == OFS_ACCEL_STEP || a == OFS_DECEL_STEP) && d[15:0] > step_q) step_q <= d[15:0];
      end
    end
  end

  // A mask of N ticks may finish up to one tick early because the first tick is partial.
  // The count still holds its old value at the edge where new pins first show, so the index checks also ask for
  // stable pins.
  assign lat = (mask_q == 8'h0) ? 32'h8 : 32'(mask_q) * 32'(MASK_TICK_CYCLES) + 32'h8;

  function automatic logic [3:0] decode(input select_pins_t p, input logic [1:0] m);
    logic [3:0] n;
    n = (m == SEL_BINARY) ? p[3:0] : 4'h0;
    for (int k = 7; k >= 1; k--) begin
      if (m != SEL_BINARY && p[k+3]) n = 4'(k);
    end
    return n;
  endfunction

  sequence s_zero_ext;
    o_preset_index == 4'h0 && fsrc_q != FSRC_PRESET && $stable(i_ext_freq) && $stable(fsrc_q) && $stable(fmax_q);
  endsequence

  a_rdata_idle:
    assert property (!$past(i_reg_req.rd) |-> o_rdata == '0) else $error("read data outside its slot");
  a_bin_index:
    assert property ((mode_q == SEL_BINARY && age_q > 8'h8 && cnt_q >= lat && $stable(i_select_pins))
      |-> o_preset_index == decode(i_select_pins, mode_q))
    else $error("binary index wrong");
  a_bit_index:
    assert property ((mode_q == SEL_BIT && age_q > 8'h8 && cnt_q >= lat && $stable(i_select_pins))
      |-> o_preset_index == decode(i_select_pins, mode_q))
    else $error("bit index wrong");
  a_mask_keep:
    assert property ((mask_q != 8'h0 && age_q > 8'h8 && $changed(o_preset_index))
      |-> cnt_q + 32'(MASK_TICK_CYCLES) >= 32'(mask_q) * 32'(MASK_TICK_CYCLES)) else $error("index moved inside mask");
  a_zero_source:
    assert property (s_zero_ext ##1 s_zero_ext |-> o_freq_ref == ((i_ext_freq > fmax_q) ? fmax_q : i_ext_freq))
    else $error("preset zero ignores source");
  a_ref_clamp:
    assert property (o_freq_ref <= fmax_q || o_freq_ref <= $past(fmax_q)) else $error("reference above maximum");
  a_ramp_up:
    assert property (o_out_freq > $past(o_out_freq) |-> (o_out_freq <= o_freq_ref || o_out_freq <= $past(o_freq_ref)))
    else $error("ramp overshoot");
  a_ramp_step:
    assert property (((o_out_freq >= $past(o_out_freq)) ? o_out_freq - $past(o_out_freq)
      : $past(o_out_freq) - o_out_freq) <= step_q) else $error("output frequency jumped");
endmodule
`default_nettype wire

//--- sim/switch_panel.sv
// Model of the switch panel that drives the select terminals.
`timescale 1ns/10ps
`default_nettype none
module switch_panel
  import preset_speed_pkg::*;
#(
  parameter int BIN_USED = 4
) (
  input  wire logic   [3:0] i_bin,
  input  wire logic   [6:0] i_bits,
  output wire select_pins_t o_pins
);
  // Unwired high binary terminals stay off, so only the low-order ones can be on.
  assign o_pins = {i_bits, i_bin & 4'((1 << BIN_USED) - 1)};
endmodule
`default_nettype wire

//--- sim/preset_speed_selector_tb.sv
// Self-checking bench for the preset speed selector.
`timescale 1ns/10ps
`default_nettype none
module preset_speed_selector_tb
  import preset_speed_pkg::*;
();
  localparam int MASK_TICK_CYCLES = 10;
  localparam int RAMP_CYCLES      = 4;
  logic         mclk;
  logic         rstn;
  logic         motor2;
  logic [15:0]  ext_freq;
  reg_req_t     req;
  logic [3:0]   bin_cmd;
  logic [6:0]   bits_cmd;
  select_pins_t pins;
  logic [31:0]  rdata;
  logic [15:0]  out_freq;
  logic [15:0]  freq_ref;
  logic [3:0]   idx;
  logic [15:0]  exp_p [16];
  int           fails;
  int           check_count;

  switch_panel i_switch_panel (.i_bin(bin_cmd), .i_bits(bits_cmd), .o_pins(pins));
  preset_speed_selector #(.MASK_TICK_CYCLES(MASK_TICK_CYCLES), .RAMP_CYCLES(RAMP_CYCLES)) i_preset_speed_selector (
    .i_mclk(mclk), .i_rstn(rstn), .i_select_pins(pins), .i_motor2_sel(motor2), .i_ext_freq(ext_freq),
    .i_reg_req(req), .o_rdata(rdata), .o_out_freq(out_freq), .o_freq_ref(freq_ref), .o_preset_index(idx));

  // Clock of 100 ns period.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  // Read data live only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic pins_hold(input logic [3:0] b, input logic [6:0] s, input int n);
    @(posedge mclk);
    bin_cmd  <= b;
    bits_cmd <= s;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // The ramp wait is bounded; a stuck ramp shows as a mismatch, not a hang.
  task automatic wait_ramp(input logic [15:0] e);
    int t;
    t = 0;
    while (out_freq !== e && t < 4000) begin
      @(posedge mclk);
      t++;
    end
    #1 chk(32'(out_freq), 32'(e));
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 5500 cycles.
  initial begin
    repeat (50000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end

  initial begin
    fails = 0;
    check_count = 0;
    req = '0;
    bin_cmd = 4'h0;
    bits_cmd = 7'h0;
    motor2 = 1'b0;
    ext_freq = 16'h1234;
    rstn = 1'b0;
    exp_p[0] = 16'h258;
    for (int n = 1; n < 16; n++) exp_p[n] = (n == 15) ? 16'h9c40 : 16'h100 + 16'(n * 16);
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd_chk(OFS_PRESET_BASE, 32'h258);
    rd_chk(OFS_PRESET_ZERO_M2, 32'h258);
    for (int n = 1; n < 16; n++) rd_chk(OFS_PRESET_BASE + 8'(4 * n), 32'h0);
    rd_chk(OFS_SELECTION_METHOD, 32'h0);
    rd_chk(OFS_SETTLE_MASK_TIME, 32'h0);
    rd_chk(8'h80, 32'h0);
    $display("reset values test done");
    reg_wr(OFS_MAXIMUM_FREQ, 32'h9c40);
    reg_wr(OFS_ACCEL_STEP, 32'h40);
    reg_wr(OFS_DECEL_STEP, 32'h40);
    for (int n = 1; n < 16; n++) reg_wr(OFS_PRESET_BASE + 8'(4 * n), 32'(exp_p[n]));
    reg_wr(OFS_PRESET_BASE + 8'h4, 32'h10);
    reg_wr(OFS_PRESET_BASE + 8'h8, 32'h9c41);
    rd_chk(OFS_PRESET_BASE + 8'h4, 32'(exp_p[1]));
    rd_chk(OFS_PRESET_BASE + 8'h8, 32'(exp_p[2]));
    rd_chk(OFS_PRESET_BASE + 8'h3c, 32'h9c40);
    for (int n = 0; n < 16; n++) begin
      pins_hold(4'(n), 7'h0, 10);
      chk(32'(idx), 32'(n));
      chk(32'(freq_ref), 32'(exp_p[n]));
    end
    $display("binary selection test done");
    reg_wr(OFS_SELECTION_METHOD, 32'h1);
    reg_wr(OFS_SELECTION_METHOD, 32'h2);
    rd_chk(OFS_SELECTION_METHOD, 32'h1);
    for (int k = 0; k < 8; k++) begin
      pins_hold(4'h5, (k == 0) ? 7'h0 : 7'(7'h7f << (k - 1)), 10);
      chk(32'(idx), 32'(k));
    end
    $display("bit selection test done");
    pins_hold(4'h5, 7'h0, 10);
    reg_wr(OFS_FREQUENCY_SOURCE, 32'h0);
    pins_hold(4'h5, 7'h0, 4);
    chk(32'(freq_ref), 32'h1234);
    reg_wr(OFS_FREQUENCY_SOURCE, 32'h2);
    reg_wr(OFS_PRESET_ZERO_M2, 32'h300);
    motor2 <= 1'b1;
    pins_hold(4'h5, 7'h0, 6);
    chk(32'(freq_ref), 32'h300);
    motor2 <= 1'b0;
    pins_hold(4'h5, 7'h0, 6);
    chk(32'(freq_ref), 32'h258);
    $display("preset zero source test done");
    reg_wr(OFS_SELECTION_METHOD, 32'h0);
    pins_hold(4'h1, 7'h0, 10);
    wait_ramp(exp_p[1]);
    pins_hold(4'hf, 7'h0, 10);
    chk(32'(out_freq < 16'h9c40), 32'h1);
    wait_ramp(16'h9c40);
    pins_hold(4'h1, 7'h0, 10);
    wait_ramp(exp_p[1]);
    $display("ramp test done");
    reg_wr(OFS_SETTLE_MASK_TIME, 32'h3);
    reg_wr(OFS_SETTLE_MASK_TIME, 32'hc9);
    rd_chk(OFS_SETTLE_MASK_TIME, 32'h3);
    pins_hold(4'h5, 7'h0, 15);
    pins_hold(4'h1, 7'h0, 50);
    chk(32'(idx), 32'h1);
    pins_hold(4'h6, 7'h0, 15);
    chk(32'(idx), 32'h1);
    pins_hold(4'h6, 7'h0, 30);
    chk(32'(idx), 32'h6);
    $display("settling mask test done");
    tally_and_finish();
  end
endmodule

bind preset_speed_selector preset_speed_checker #(.MASK_TICK_CYCLES(MASK_TICK_CYCLES), .RAMP_CYCLES(RAMP_CYCLES))
  i_preset_speed_checker (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_select_pins(i_select_pins), .i_motor2_sel(i_motor2_sel),
  .i_ext_freq(i_ext_freq), .i_reg_req(i_reg_req), .o_rdata(o_rdata), .o_out_freq(o_out_freq),
  .o_freq_ref(o_freq_ref), .o_preset_index(o_preset_index));
`default_nettype wire
